// ===== design/ssd_map.svh
// source select delegation: offsets, field positions, reset values
// assumes 32-bit axi4-lite word addressing, 4 stages
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH
`define SSD_NUM_STAGES 4
`define SSD_NUM_BUSES 12
`define SSD_NUM_BUTTONS 36
`define SSD_MAP_ENTRIES 72
`define SSD_SRC_W 7
`define SSD_NO_SOURCE 7'h7f
// register byte offsets
`define SSD_REG_MAP_ADDR 12'h000
`define SSD_REG_MAP_DATA 12'h004
`define SSD_REG_PREF 12'h008
`define SSD_REG_PREF_HI 12'h02c
`define SSD_REG_CFG 12'h00c
`define SSD_REG_STATUS 12'h010
`define SSD_REG_SEL_BASE 12'h100
`define SSD_REG_REENTRY 12'h200
// cfg fields
`define SSD_CFG_FXSEND_LSB 0
`define SSD_CFG_INTLOOP_LSB 4
`define SSD_CFG_XFORM_FITTED 8
`define SSD_CFG_HD_VARIANT 9
// re-entry source ids: stage n output is source 64+n
`define SSD_REENTRY_BASE 7'h40
`endif

// ===== design/ssd_pkg.sv
// source select delegation: shared types
// assumes ssd_map.svh constants
package ssd_pkg;
  typedef enum logic [1:0] {
    SSD_AX_IDLE = 2'b00,
    SSD_AX_RESP = 2'b01
  } ssd_axi_state_t;
endpackage

// ===== design/ssd_top.sv
// source select delegation core with axi4-lite register slave
// assumes one 20 mhz clock, panel buttons asynchronous to it
// How it works
// [RQ1] map 72 entries, 36 unshifted, 36 shifted
// [RQ2] shifted preference, no modifier: shifted source
// [RQ3] unshifted preference, no modifier: unshifted source
// [RQ4] shift held: always shifted source
// [RQ5] unshift held: always unshifted source
// [RQ6] each bus keeps its own preference
// [RQ7] single mapped source wins regardless
// [RQ8] any stage output selectable elsewhere
// [RQ9] re-entry forming a loop is refused; code refuses only self re-entry and direct two-stage loops
// [RQ10] twelve buses per stage
// [RQ11] no modifier: key1 fill, key2 fill, bkgd a/b
// [RQ12] alt rows: key3, key4 fill, utility 1/2
// [RQ13] cut modifier: key rows hit cut buses
// [RQ14] modifiers combine, alt plus cut works
// [RQ15] report selections and next target bus
// [RQ16] effects send loops keyer pair back
// [RQ17] internal loop needs option, hd no external
// [RQ18] modifiers sampled at press, applied next cycle
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // axi4-lite
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // panel: press strobe level, button index, stage, modifiers
  input wire logic btn_press_in,
  input wire logic [5:0] btn_index_in,
  input wire logic [1:0] btn_stage_in,
  input wire logic mod_shift_in,
  input wire logic mod_unshift_in,
  input wire logic mod_alt_in,
  input wire logic mod_cut_in,
  // per stage target bus and effects routing
  output logic [15:0] target_bus_out,
  output logic [3:0] fx_send_active_out,
  output logic [3:0] fx_internal_out,
  output logic press_done_out
);
  import ssd_pkg::*;
  // assertions sample on the system clock, quiet in reset
  default clocking ssd_cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // ************************************
  // helper functions
  // ************************************
  // bus index from row and modifiers: rows 0..3 = key-a fill, key-b fill, bg-a, bg-b
  function automatic logic [3:0] target_of(input logic [1:0] row, input logic alt, input logic cut);
    logic [3:0] t;
    t = 4'h0;
    case (row)
      2'd0: t = alt ? (cut ? 4'h5 : 4'h4) : (cut ? 4'h1 : 4'h0); // RQ11 RQ12 RQ13 RQ14
      2'd1: t = alt ? (cut ? 4'h7 : 4'h6) : (cut ? 4'h3 : 4'h2); // RQ14
      2'd2: t = alt ? 4'ha : 4'h8; // RQ12
      default: t = alt ? 4'hb : 4'h9;
    endcase
    return t;
  endfunction

  // ************************************
  // input synchronisers, three stages
  // ************************************
  logic [12:0] sync1, sync2, sync3, stable, next_stable;
  logic press_q, next_press_q;
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < 13; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_stable[i] = sync3[i];
      end
    end
    next_press_q = stable[0];
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
      sync3 <= 13'h0000;
      stable <= 13'h0000;
      press_q <= 1'b0;
    end else begin
      sync1 <= {mod_cut_in, mod_alt_in, mod_unshift_in, mod_shift_in, btn_stage_in, btn_index_in[5:0], btn_press_in};
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= next_stable;
      press_q <= next_press_q;
    end
  end
  wire press_edge = stable[0] & ~press_q;
  wire [5:0] s_btn = stable[6:1];
  wire [1:0] s_stage = stable[8:7];
  wire s_shift = stable[9];
  wire s_unshift = stable[10];
  wire s_alt = stable[11];
  wire s_cut = stable[12];

  // ************************************
  // state: map, preferences, selections
  // ************************************
  logic [`SSD_SRC_W-1:0] btn_map [0:`SSD_MAP_ENTRIES-1]; // RQ1
  logic [`SSD_SRC_W-1:0] sel [0:`SSD_NUM_STAGES*`SSD_NUM_BUSES-1]; // RQ10
  logic [47:0] pref; // RQ6 one bit per bus per stage
  logic [6:0] map_addr;
  logic [15:0] cfg;
  logic [15:0] feeds; // feeds[d*4+s]: stage s output enters stage d
  logic [15:0] next_tgt;
  logic refused;

  // press capture: whole synchronised vector latched on the press edge
  logic cap_v;
  logic [12:0] cap;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cap_v <= 1'b0;
      cap <= 13'h0000;
    end else begin
      cap_v <= press_edge; // RQ18
      if (press_edge) begin
        cap <= stable;
      end
    end
  end
  wire [5:0] cap_btn = cap[6:1];
  wire [1:0] cap_stage = cap[8:7];
  wire cap_shift = cap[9];
  wire cap_unshift = cap[10];
  wire cap_alt = cap[11];
  wire cap_cut = cap[12];
  sequence s_press_cap;
    press_edge ##1 cap_v;
  endsequence
  a_press_apply: assert property (s_press_cap |=> press_done_out) else $error("press not applied"); // RQ18

  // source resolution for the captured press
  logic [5:0] bus_idx;
  logic [3:0] bus_t;
  logic [6:0] src_u, src_s, src_pick;
  logic use_shift, loop_bad;
  always_comb begin
    bus_t = target_of(cap_btn[1:0], cap_alt, cap_cut);
    bus_idx = 6'({2'b00, cap_stage} * 6'd12 + {2'b00, bus_t});
    src_u = btn_map[cap_btn < 6'd36 ? cap_btn : 6'd0];
    src_s = btn_map[7'(cap_btn < 6'd36 ? cap_btn : 6'd0) + 7'd36];
    if (cap_shift) begin
      use_shift = 1'b1; // RQ4
    end else if (cap_unshift) begin
      use_shift = 1'b0; // RQ5
    end else begin
      use_shift = pref[bus_idx]; // RQ2 RQ3 RQ6
    end
    if (src_s == `SSD_NO_SOURCE) begin
      src_pick = src_u; // RQ7
    end else if (src_u == `SSD_NO_SOURCE) begin
      src_pick = src_s; // RQ7
    end else begin
      src_pick = use_shift ? src_s : src_u;
    end
    // re-entry of stage k into cap_stage refused if k is cap_stage or cap_stage output already feeds k directly
    loop_bad = 1'b0;
    if (src_pick >= `SSD_REENTRY_BASE && src_pick < `SSD_REENTRY_BASE + 7'd4) begin
      loop_bad = (src_pick[1:0] == cap_stage) | feeds[{src_pick[1:0], cap_stage}]; // RQ8 RQ9
    end
  end
  a_shift_pick: assert property (cap_v && cap_shift |-> use_shift) else $error("shift lost"); // RQ4
  a_unshift_pick: assert property (cap_v && cap_unshift && !cap_shift |-> !use_shift) else $error("unshift"); // RQ5
  a_single_src: assert property (cap_v && src_s == `SSD_NO_SOURCE |-> src_pick == src_u) else $error("single"); // RQ7
  a_loop_refused: assert property (cap_v && loop_bad |=> refused) else $error("loop kept"); // RQ9

  // target bus report per stage, live modifiers
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      next_tgt[s*4 +: 4] = target_of(s_btn[1:0], s_alt, s_cut); // RQ15
    end
  end

  // ************************************
  // axi4-lite slave
  // ************************************
  ssd_axi_state_t wst, next_wst, rst_st, next_rst;
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [11:0] awa, next_awa;
  logic [31:0] wd, next_wd, rd, next_rd;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  wire do_wr = (wst == SSD_AX_IDLE) && next_aw_got && next_w_got;
  always_comb begin
    next_wst = wst;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awa = awa;
    next_wd = wd;
    next_bresp = bresp;
    if (wst == SSD_AX_IDLE) begin
      if (s_axi_awvalid_in && !aw_got) begin
        next_aw_got = 1'b1;
        next_awa = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_got) begin
        next_w_got = 1'b1;
        next_wd = s_axi_wdata_in;
      end
      if (next_aw_got && next_w_got) begin
        next_wst = SSD_AX_RESP;
        next_bresp = (next_awa <= `SSD_REG_CFG || (next_awa >= `SSD_REG_SEL_BASE && next_awa < 12'h1c0)
                      || next_awa == `SSD_REG_REENTRY || next_awa == `SSD_REG_PREF_HI) ? 2'b00 : 2'b10;
      end
    end else if (s_axi_bready_in) begin
      next_wst = SSD_AX_IDLE;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
    end
  end
  always_comb begin
    next_rst = rst_st;
    next_rd = rd;
    next_rresp = rresp;
    if (rst_st == SSD_AX_IDLE) begin
      if (s_axi_arvalid_in) begin
        next_rst = SSD_AX_RESP;
        next_rresp = 2'b00;
        next_rd = 32'h0;
        case (s_axi_araddr_in)
          `SSD_REG_MAP_ADDR: next_rd = {25'h0, map_addr};
          `SSD_REG_MAP_DATA: next_rd = {25'h0, btn_map[map_addr < 7'd72 ? map_addr : 7'd0]};
          `SSD_REG_PREF: next_rd = pref[31:0];
          `SSD_REG_CFG: next_rd = {16'h0, cfg};
          `SSD_REG_STATUS: next_rd = {15'h0, refused, target_bus_out};
          `SSD_REG_REENTRY: next_rd = {16'h0, feeds};
          default: begin
            if (s_axi_araddr_in >= `SSD_REG_SEL_BASE && s_axi_araddr_in < 12'h1c0) begin
              next_rd = {25'h0, sel[6'(s_axi_araddr_in[7:2])]}; // RQ15
            end else if (s_axi_araddr_in == `SSD_REG_PREF_HI) begin
              next_rd = {16'h0, pref[47:32]};
            end else begin
              next_rresp = 2'b10;
            end
          end
        endcase
      end
    end else if (s_axi_rready_in) begin
      next_rst = SSD_AX_IDLE;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wst <= SSD_AX_IDLE;
      rst_st <= SSD_AX_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awa <= 12'h000;
      wd <= 32'h0;
      rd <= 32'h0;
      bresp <= 2'b00;
      rresp <= 2'b00;
    end else begin
      wst <= next_wst;
      rst_st <= next_rst;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awa <= next_awa;
      wd <= next_wd;
      rd <= next_rd;
      bresp <= next_bresp;
      rresp <= next_rresp;
    end
  end

  // ************************************
  // register and selection updates
  // ************************************
  logic [3:0] fx_int_n, fx_send_n;
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      // internal loop only with the option; hd variant forces internal or nothing
      fx_int_n[s] = cfg[`SSD_CFG_INTLOOP_LSB + s] & cfg[`SSD_CFG_XFORM_FITTED]; // RQ17
      fx_send_n[s] = cfg[`SSD_CFG_FXSEND_LSB + s] & (fx_int_n[s] | ~cfg[`SSD_CFG_HD_VARIANT]); // RQ16 RQ17
    end
  end
  a_loop_option: assert property (!cfg[`SSD_CFG_XFORM_FITTED] |-> fx_int_n == 4'h0) else $error("no option"); // RQ17
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      map_addr <= 7'h00;
      pref <= 48'h0;
      cfg <= 16'h0000;
      feeds <= 16'h0000;
      refused <= 1'b0;
      for (int i = 0; i < `SSD_MAP_ENTRIES; i++) begin
        btn_map[i] <= `SSD_NO_SOURCE;
      end
      for (int i = 0; i < 48; i++) begin
        sel[i] <= 7'h00;
      end
    end else begin
      if (do_wr) begin
        case (next_awa)
          `SSD_REG_MAP_ADDR: map_addr <= next_wd[6:0];
          `SSD_REG_MAP_DATA: begin
            if (map_addr < 7'd72) begin
              btn_map[map_addr] <= next_wd[6:0]; // RQ1
            end
            map_addr <= map_addr + 7'd1;
          end
          `SSD_REG_PREF: pref[31:0] <= next_wd; // RQ6
          `SSD_REG_CFG: cfg <= next_wd[15:0];
          `SSD_REG_REENTRY: feeds <= next_wd[15:0];
          default: begin
            if (next_awa == `SSD_REG_PREF_HI) begin
              pref[47:32] <= next_wd[15:0];
            end
          end
        endcase
      end
      // a press lands after any register write, so its feed set wins
      if (cap_v) begin
        refused <= loop_bad; // RQ9
        if (!loop_bad && src_pick != `SSD_NO_SOURCE) begin
          sel[bus_idx] <= src_pick; // RQ18
          if (src_pick >= `SSD_REENTRY_BASE && src_pick < `SSD_REENTRY_BASE + 7'd4) begin
            feeds[{cap_stage, src_pick[1:0]}] <= 1'b1; // RQ8
          end
        end
      end
    end
  end

  // panel-side outputs straight from flops; axi handshake outputs decoded from state flops
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      target_bus_out <= 16'h0000;
      fx_send_active_out <= 4'h0;
      fx_internal_out <= 4'h0;
      press_done_out <= 1'b0;
    end else begin
      target_bus_out <= next_tgt;
      fx_send_active_out <= fx_send_n[3:0];
      fx_internal_out <= fx_int_n[3:0];
      press_done_out <= cap_v;
    end
  end
  assign s_axi_awready_out = 1'b0 | (wst == SSD_AX_IDLE && !aw_got);
  assign s_axi_wready_out = (wst == SSD_AX_IDLE && !w_got);
  assign s_axi_bvalid_out = (wst == SSD_AX_RESP);
  assign s_axi_bresp_out = bresp;
  assign s_axi_arready_out = (rst_st == SSD_AX_IDLE);
  assign s_axi_rvalid_out = (rst_st == SSD_AX_RESP);
  assign s_axi_rdata_out = rd;
  assign s_axi_rresp_out = rresp;
endmodule

// ===== dv/ssd_panel.sv
// operator panel model: source buttons and held modifiers
// assumes the bench calls push after a rising edge of clk_in
`timescale 1ns/1ps
module ssd_panel (
  input wire logic clk_in,
  input wire logic [15:0] target_bus_in,
  input wire logic press_done_in,
  output logic btn_press_out,
  output logic [5:0] btn_index_out,
  output logic [1:0] btn_stage_out,
  output logic [3:0] mods_out
);
  // ************
  // button press
  // ************
  // idle panel: nothing held
  initial begin
    btn_press_out = 1'b0;
    btn_index_out = 6'h00;
    btn_stage_out = 2'h0;
    mods_out = 4'h0;
  end

  // mods = {shift, unshift, alt, cut}; held before and after the press
  task automatic push(input logic [5:0] b, input logic [1:0] st, input logic [3:0] m,
                      input logic [3:0] tb, output logic [3:0] tseen, output logic done);
    int n;
    done = 1'b0;
    n = 0;
    @(posedge clk_in);
    btn_index_out <= b;
    btn_stage_out <= st;
    mods_out <= m;
    // let the modifiers settle through the synchronisers
    do begin
      @(posedge clk_in);
      n++;
    end while (target_bus_in[{st, 2'b00} +: 4] !== tb && n < 12);
    tseen = target_bus_in[{st, 2'b00} +: 4];
    btn_press_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
      if (press_done_in === 1'b1) begin
        done = 1'b1;
      end
    end while (!done && n < 30);
    btn_press_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    mods_out <= 4'h0;
    btn_index_out <= ~b; // released index lines show no stale value
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ===== dv/ssd_top_bench.sv
// self-checking bench for the source select delegation core
// assumes ssd_map.svh offsets and the panel model in ssd_panel.sv
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_top_bench;
  // ************
  // bench setup
  // ************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, press, done;
  logic [1:0] bresp, rresp, bstg;
  logic [5:0] bidx;
  logic [3:0] mods, fxs, fxi;
  logic [15:0] target;
  int mismatches = 0;
  int checks = 0;

  // clock at 50 ns period
  always #25 clk = ~clk;

  ssd_top u_dut (.clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .btn_press_in(press), .btn_index_in(bidx), .btn_stage_in(bstg), .mod_shift_in(mods[3]),
    .mod_unshift_in(mods[2]), .mod_alt_in(mods[1]), .mod_cut_in(mods[0]), .target_bus_out(target),
    .fx_send_active_out(fxs), .fx_internal_out(fxi), .press_done_out(done));

  ssd_panel u_panel (.clk_in(clk), .target_bus_in(target), .press_done_in(done), .btn_press_out(press),
    .btn_index_out(bidx), .btn_stage_out(bstg), .mods_out(mods));

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // axi4-lite write: address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(what, exp, d);
  endtask

  // one press, then read back the selected bus
  task automatic sel(input logic [1:0] st, input logic [5:0] b, input logic [3:0] m,
                     input logic [5:0] bus, input logic [6:0] src);
    logic [3:0] t;
    logic ok;
    u_panel.push(b, st, m, bus[3:0], t, ok);
    cmp("target bus", {28'h0, bus[3:0]}, {28'h0, t});
    cmp("press done", 32'h1, {31'h0, ok});
    rd_chk(`SSD_REG_SEL_BASE + {4'h0, st * 6'd12 + bus, 2'b00}, {25'h0, src}, "selection");
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    cmp("target after reset", 32'h0, {16'h0, target});
    rd_chk(`SSD_REG_STATUS, 32'h0, "status");
    rd_chk(`SSD_REG_SEL_BASE + 12'h0bc, 32'h0, "last selection");
    rd(12'hffc, d, r);
    cmp("unmapped rresp", 32'h2, {30'h0, r});
    wr(12'hff0, 32'h1, r);
    cmp("unmapped bresp", 32'h2, {30'h0, r});
    $display("test reset done");
  endtask

  task automatic t_select();
    logic [1:0] r;
    logic [3:0] t;
    logic ok;
    wr(`SSD_REG_MAP_ADDR, 32'd0, r);
    wr(`SSD_REG_MAP_DATA, 32'h05, r);
    wr(`SSD_REG_MAP_DATA, 32'h41, r);
    wr(`SSD_REG_MAP_DATA, 32'h09, r);
    wr(`SSD_REG_MAP_DATA, 32'h40, r);
    wr(`SSD_REG_MAP_ADDR, 32'd36, r);
    wr(`SSD_REG_MAP_DATA, 32'h25, r);
    wr(`SSD_REG_MAP_ADDR, 32'd71, r);
    wr(`SSD_REG_MAP_DATA, 32'h26, r);
    wr(`SSD_REG_PREF, 32'h1, r);
    wr(`SSD_REG_PREF_HI, 32'h8000, r);
    cmp("pref hi bresp", 32'h0, {30'h0, r});
    rd_chk(`SSD_REG_PREF_HI, 32'h8000, "pref hi");
    rd_chk(`SSD_REG_PREF, 32'h1, "pref lo");
    sel(2'd0, 6'd0, 4'b0000, 6'd0, 7'h25);
    sel(2'd0, 6'd2, 4'b0000, 6'd8, 7'h09);
    sel(2'd0, 6'd0, 4'b0100, 6'd0, 7'h05);
    sel(2'd0, 6'd0, 4'b0010, 6'd4, 7'h05);
    sel(2'd0, 6'd0, 4'b1010, 6'd4, 7'h25);
    sel(2'd0, 6'd0, 4'b0001, 6'd1, 7'h05);
    sel(2'd0, 6'd0, 4'b0011, 6'd5, 7'h05);
    sel(2'd0, 6'd2, 4'b1010, 6'd10, 7'h09);
    sel(2'd2, 6'd35, 4'b0100, 6'd9, 7'h26);
    sel(2'd0, 6'd1, 4'b0000, 6'd2, 7'h41);
    // stage 1 taking stage 0 output would close a loop
    u_panel.push(6'd3, 2'd1, 4'h0, 4'h9, t, ok);
    cmp("refused target", 32'h9, {28'h0, t});
    cmp("refused press done", 32'h1, {31'h0, ok});
    rd_chk(`SSD_REG_SEL_BASE + 12'h054, 32'h0, "looped selection");
    rd_chk(`SSD_REG_STATUS, 32'h10000, "refused flag");
    $display("test select done");
  endtask

  task automatic fx(input logic [11:0] cfg, input logic [7:0] exp);
    logic [1:0] r;
    int n;
    n = 0;
    wr(`SSD_REG_CFG, {20'h0, cfg}, r);
    do begin
      @(posedge clk);
      n++;
    end while ({fxs, fxi} !== exp && n < 8);
    cmp("fx routing", {24'h0, exp}, {24'h0, fxs, fxi});
  endtask

  task automatic t_fx();
    fx(12'h001, 8'h10);
    fx(12'h011, 8'h10);
    fx(12'h111, 8'h11);
    fx(12'h201, 8'h00);
    fx(12'h311, 8'h11);
    fx(12'h0f8, 8'h80);
    $display("test fx done");
  endtask

  // reset again in mid-run: routing, selections and status return to zero
  task automatic t_midreset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp("fx after reset", 32'h0, {24'h0, fxs, fxi});
    cmp("target after reset", 32'h0, {16'h0, target});
    rd_chk(`SSD_REG_SEL_BASE, 32'h0, "selection after reset");
    rd_chk(`SSD_REG_STATUS, 32'h0, "status after reset");
    $display("test midreset done");
  endtask

  // main sequence: reset for 5 cycles, then the tests
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_select();
    t_fx();
    t_midreset();
    summarize();
  end
endmodule
